/* File: logic/vci_crc6.v */
// copy-management crc, polynomial x^6 + x + 1, all-ones preset
`timescale 1ns/1ps
`include "vci_defs.vh"
module vci_crc6 (
  // fourteen data bits, c0 first
  input  wire [13:0] data_bits,
  // crc bits c14..c19
  output wire [5:0]  crc_bits
);
  // serial lfsr unrolled by a loop over the data bits
  function [5:0] crc_step;
    input [5:0] crc;
    input       bit_in;
    reg         fb;
    begin
      fb       = crc[5] ^ bit_in;
      crc_step = {crc[4:1], crc[0] ^ fb, fb};
    end
  endfunction

  wire [5:0] chain [0:14];
  assign chain[0] = `VCI_CRC_PRESET;
  genvar i;
  generate
    for (i = 0; i < 14; i = i + 1)
    begin : g_step
      assign chain[i+1] = crc_step(chain[i], data_bits[i]);
    end
  endgenerate
  // c14 is the first crc bit sent, taken from the top of the register
  assign crc_bits = {chain[14][0], chain[14][1], chain[14][2],
                     chain[14][3], chain[14][4], chain[14][5]};
endmodule // vci_crc6

/* File: logic/vci_defs.vh */
// constants for the vertical blanking caption and copy-management inserter
`ifndef VCI_DEFS_VH
`define VCI_DEFS_VH
// line numbers of the inserted lines
`define VCI_CC_LINE_ODD      10'h015
`define VCI_CC_LINE_EVEN     10'h11c
`define VCI_CGMS_LINE_ODD    10'h014
`define VCI_CGMS_LINE_EVEN   10'h11b
// caption bit of 1986 ns in 50 ns cycles, and its low half
`define VCI_CC_BIT_CYC       8'h27
`define VCI_CC_HALF_CYC      8'h13
// copy-management bit of 2235 ns in 50 ns cycles
`define VCI_CGMS_BIT_CYC     8'h2c
// start of inserted data, 10500 ns after line start
`define VCI_DATA_START_CYC   10'h0d2
// run-in cycles, half bits per run-in cycle
`define VCI_RUNIN_CYCLES     7
// caption frame: 14 half bits run-in, 2 blank bits, start, 16 data
`define VCI_CC_RUNIN_HALVES  5'h0e
`define VCI_CC_FRAME_BITS    5'h13
// copy-management frame: reference pulse + 20 bits
`define VCI_CGMS_BITS        5'h14
`define VCI_CRC_PRESET       6'h3f
// output levels
`define VCI_LVL_BLANK        8'h10
`define VCI_LVL_HIGH         8'h7e
`define VCI_FIFO_DEPTH       8
`define VCI_FIFO_AW          3
`endif

/* File: logic/vci_fifo.v */
// small valid/ready fifo for the outgoing sample stream
`timescale 1ns/1ps
module vci_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // honest full and empty flags
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg];

  // storage write
  always @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers and fill count
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // vci_fifo

/* File: logic/vci_inserter.v */
// line 20/21 and 283/284 blanking-data inserter for the video path
`timescale 1ns/1ps
`include "vci_defs.vh"
// Operation
// - captions on line 21 odd, 284 even
// - seven-cycle run-in locked to bit clock
// - two blank bits then start bit one
// - two bytes, seven bits plus odd parity
// - extended bytes sent on even-field line 284
// - pixel input ignored on caption lines
// - single-buffered bytes, sent next caption line
// - copy-management on line 20 odd, 283 even
// - separate odd and even enables
// - copy-management only in ntsc mode
// - twenty bits after one-bit reference pulse
// - c0-7 third, c8-15 second, c16-19 first
// - auto crc computes c14-c19 from c0-c13
// - crc off sends register bits as held
// - enable bit set turns field output on
// - extended bytes in two 8-bit registers
module vci_inserter (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // line and field timing from the encoder
  input  wire       line_start,
  input  wire [9:0] line_number,
  input  wire       field_even,
  input  wire       ntsc_mode,
  // incoming pixel samples
  input  wire       pix_valid,
  output wire       pix_ready,
  input  wire [7:0] pix_data,
  // caption bytes, odd and even fields
  input  wire [7:0] caption_bytes_lo,
  input  wire [7:0] caption_bytes_hi,
  input  wire [7:0] extended_caption_bytes_lo,
  input  wire [7:0] extended_caption_bytes_hi,
  input  wire       caption_load,
  input  wire       extended_caption_load,
  // copy-management configuration
  input  wire [7:0] copy_mgmt_reg_first,
  input  wire [7:0] copy_mgmt_reg_second,
  input  wire [7:0] copy_mgmt_reg_third,
  // outgoing sample stream
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data,
  // status
  output reg        insert_active
);
  // ==========================================================
  // configuration fields
  // ==========================================================
  wire       cgms_crc_auto_enable   = copy_mgmt_reg_first[4];
  wire       cgms_odd_field_enable  = copy_mgmt_reg_first[5];
  wire       cgms_even_field_enable = copy_mgmt_reg_first[6];

  localparam ST_IDLE  = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_CC    = 2'h2;
  localparam ST_CGMS  = 2'h3;

  localparam [7:0] BIT_CC   = `VCI_CC_BIT_CYC;
  localparam [7:0] BIT_CG   = `VCI_CGMS_BIT_CYC;
  localparam [7:0] HALF_CC  = `VCI_CC_HALF_CYC;
  localparam [9:0] START_CY = `VCI_DATA_START_CYC;

  // odd parity over seven data bits
  function [7:0] cc_byte;
    input [7:0] b;
    begin
      cc_byte = {~(^b[6:0]), b[6:0]};
    end
  endfunction

  // ==========================================================
  // caption byte buffers, one deep
  // ==========================================================
  reg [15:0] cc_odd_reg;
  reg [15:0] cc_even_reg;
  // a load holds until the next load of that buffer; each caption line resends it
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cc_odd_reg  <= 16'h0000;
      cc_even_reg <= 16'h0000;
    end
    else
    begin
      if (caption_load)
        cc_odd_reg <= {caption_bytes_hi, caption_bytes_lo};
      if (extended_caption_load)
        cc_even_reg <= {extended_caption_bytes_hi,
                        extended_caption_bytes_lo};
    end
  end

  // ==========================================================
  // copy-management word build
  // ==========================================================
  wire [5:0]  crc_bits;
  wire [19:0] cgms_raw;
  wire [19:0] cgms_word;
  // bit mapping from the three registers
  assign cgms_raw = {copy_mgmt_reg_first[3:0], copy_mgmt_reg_second,
                     copy_mgmt_reg_third};

  vci_crc6 u_crc (
    .data_bits (cgms_raw[13:0]),
    .crc_bits  (crc_bits)
  );

  assign cgms_word = cgms_crc_auto_enable ?
                     {crc_bits[5:0], cgms_raw[13:0]} : cgms_raw;

  // ==========================================================
  // line decode
  // ==========================================================
  // caption and copy-management line select per field
  wire cc_line   = field_even ?
                   (line_number == `VCI_CC_LINE_EVEN) :
                   (line_number == `VCI_CC_LINE_ODD);
  wire cg_line   = field_even ?
                   (line_number == `VCI_CGMS_LINE_EVEN) :
                   (line_number == `VCI_CGMS_LINE_ODD);
  // a set bit turns output on
  wire cg_fen    = field_even ? cgms_even_field_enable :
                   cgms_odd_field_enable;
  wire cg_go     = cg_line & cg_fen & ntsc_mode;

  // ==========================================================
  // sequencer
  // ==========================================================
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [9:0]  delay_reg;
  reg  [7:0]  phase_reg;
  reg  [4:0]  bit_reg;
  reg  [4:0]  half_reg;
  reg         inrun_reg;
  reg  [19:0] shift_reg;
  reg         level_reg;
  reg         is_cc_reg;
  reg  [7:0]  samp_reg;
  reg         samp_vld_reg;

  wire [7:0]  bit_len   = is_cc_reg ? BIT_CC : BIT_CG;
  wire        bit_end   = (phase_reg == bit_len - 8'h01);
  // run-in high halves get one extra cycle so that a whole run-in
  // cycle spans exactly one caption bit period
  wire        half_end  = half_reg[0] ? (phase_reg == HALF_CC - 8'h01) :
                                        (phase_reg == HALF_CC);
  wire        fifo_ready;

  // ==========================================================
  // line start capture
  // ==========================================================
  // a line start that meets a full fifo is kept until the
  // sequencer may move, so a stalled cycle never loses a line
  reg         start_pend_reg;
  wire        start_req = (line_start & (cc_line | cg_go)) |
                          start_pend_reg;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      start_pend_reg <= 1'b0;
    else
      start_pend_reg <= start_req & ~fifo_ready;
  end

  // next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_req)
          state_next = ST_WAIT;
      ST_WAIT:
        if (delay_reg == START_CY)
          state_next = is_cc_reg ? ST_CC : ST_CGMS;
      ST_CC:
        if (~inrun_reg & bit_end & (bit_reg == `VCI_CC_FRAME_BITS))
          state_next = ST_IDLE;
      ST_CGMS:
        if (bit_end & (bit_reg == `VCI_CGMS_BITS))
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // timing counters and serial data
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      delay_reg <= 10'h000;
      phase_reg <= 8'h00;
      bit_reg   <= 5'h00;
      half_reg  <= 5'h00;
      inrun_reg <= 1'b0;
      shift_reg <= 20'h00000;
      level_reg <= 1'b0;
      is_cc_reg <= 1'b0;
    end
    else if (fifo_ready)
    begin
      state_reg <= state_next;
      case (state_reg)
        ST_IDLE:
        begin
          delay_reg <= 10'h000;
          phase_reg <= 8'h00;
          bit_reg   <= 5'h00;
          half_reg  <= 5'h00;
          level_reg <= 1'b0;
          is_cc_reg <= cc_line;
          inrun_reg <= cc_line;
          // even field takes the extended bytes
          if (cc_line)
            shift_reg <= {4'h0, field_even ?
                {cc_byte(cc_even_reg[15:8]), cc_byte(cc_even_reg[7:0])} :
                {cc_byte(cc_odd_reg[15:8]), cc_byte(cc_odd_reg[7:0])}};
          else
            shift_reg <= cgms_word;
        end
        ST_WAIT:
        begin
          delay_reg <= delay_reg + 10'h001;
          // reference pulse high for one bit
          // run-in also opens high on this edge, full first half
          level_reg <= (delay_reg == START_CY);
        end
        ST_CC:
        begin
          if (inrun_reg)
          begin
            // run-in toggles each half bit, seven cycles
            phase_reg <= half_end ? 8'h00 : phase_reg + 8'h01;
            if (half_end)
            begin
              half_reg  <= half_reg + 5'h01;
              level_reg <= ~level_reg & (half_reg !=
                                         `VCI_CC_RUNIN_HALVES - 5'h01);
              if (half_reg == `VCI_CC_RUNIN_HALVES - 5'h01)
                inrun_reg <= 1'b0;
            end
          end
          else
          begin
            phase_reg <= bit_end ? 8'h00 : phase_reg + 8'h01;
            if (bit_end)
            begin
              bit_reg <= bit_reg + 5'h01;
              // bits 0-1 blank, bit 2 start
              if (bit_reg == 5'h01)
                level_reg <= 1'b1;
              else if (bit_reg >= 5'h02)
              begin
                level_reg <= shift_reg[0];
                shift_reg <= {1'b0, shift_reg[19:1]};
              end
              else
                level_reg <= 1'b0;
            end
          end
        end
        ST_CGMS:
        begin
          phase_reg <= bit_end ? 8'h00 : phase_reg + 8'h01;
          if (bit_end)
          begin
            bit_reg   <= bit_reg + 5'h01;
            level_reg <= shift_reg[0];
            shift_reg <= {1'b0, shift_reg[19:1]};
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sample mux into the output fifo
  // ==========================================================
  wire on_vbi_line = cc_line | cg_go;
  assign pix_ready = fifo_ready;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      samp_reg      <= `VCI_LVL_BLANK;
      samp_vld_reg  <= 1'b0;
      insert_active <= 1'b0;
    end
    else if (fifo_ready)
    begin
      insert_active <= (state_reg != ST_IDLE);
      if (cc_line | (state_reg != ST_IDLE))
      begin
        samp_reg     <= level_reg ? `VCI_LVL_HIGH : `VCI_LVL_BLANK;
        samp_vld_reg <= 1'b1;
      end
      else
      begin
        samp_reg     <= on_vbi_line ? `VCI_LVL_BLANK : pix_data;
        samp_vld_reg <= pix_valid;
      end
    end
  end

  vci_fifo #(
    .WIDTH (8),
    .DEPTH (`VCI_FIFO_DEPTH),
    .AW    (`VCI_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (samp_vld_reg),
    .in_ready  (fifo_ready),
    .in_data   (samp_reg),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );
endmodule // vci_inserter

/* File: sim/test_vci_inserter.sv */
// self-checking bench for the vbi inserter
`timescale 1ns/1ps
module test_vci_inserter;
  reg        ref_clk, rst, line_start, field_even, ntsc_mode, stall;
  reg        pix_valid, cc_load, ex_load;
  reg  [9:0] line_number;
  reg  [7:0] pix_data, cc_lo, cc_hi, ex_lo, ex_hi, cm1, cm2, cm3;
  wire       pix_ready, out_valid, out_ready, insert_active;
  wire [7:0] out_data;
  integer    err_count = 0, checked = 0, tick = 0;
  vci_inserter i_vci_inserter (
    .ref_clk(ref_clk), .rst(rst), .line_start(line_start),
    .line_number(line_number), .field_even(field_even),
    .ntsc_mode(ntsc_mode), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_data(pix_data), .caption_bytes_lo(cc_lo),
    .caption_bytes_hi(cc_hi), .extended_caption_bytes_lo(ex_lo),
    .extended_caption_bytes_hi(ex_hi), .caption_load(cc_load),
    .extended_caption_load(ex_load), .copy_mgmt_reg_first(cm1),
    .copy_mgmt_reg_second(cm2), .copy_mgmt_reg_third(cm3),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .insert_active(insert_active));
  vci_tv_model i_vci_tv_model (.ref_clk(ref_clk), .rst(rst),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .stall(stall));
  // compare and count
  task cmp(input [31:0] a, input [31:0] e);
    begin
      checked++;
      if (a !== e)
      begin
        err_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
      end
    end
  endtask
  // copy-management frame with optional crc over c0..c13
  function [19:0] cg_exp(input [7:0] f, s, t);
    reg [5:0] r;
    reg       b;
    integer   k;
    begin
      cg_exp = {f[3:0], s, t};
      r = 6'h3f;
      for (k = 0; k < 14; k++)
      begin
        b = r[5] ^ cg_exp[k];
        r = {r[4:0], b} ^ {4'h0, b, 1'b0};
      end
      if (f[4])
        for (k = 0; k < 6; k++)
          cg_exp[14 + k] = r[5 - k];
    end
  endfunction
  // one video line of 1600 cycles
  task run_line(input [9:0] n);
    begin
      i_vci_tv_model.got.delete();
      line_number = n;
      field_even = (n > 10'h106);
      line_start = 1'b1;
      @(posedge ref_clk) #1;
      line_start = 1'b0;
      repeat (1599) @(posedge ref_clk) #1;
    end
  endtask
  // load bytes on the line before, check both on the caption line
  task t_caption(input ev, input [7:0] lo, input [7:0] hi);
    reg [15:0] v;
    integer    h, p;
    begin
      run_line(ev ? 10'h11b : 10'h014);
      {cc_lo, cc_hi, cc_load} = ev ? {cc_lo, cc_hi, 1'b0} : {lo, hi, 1'b1};
      {ex_lo, ex_hi, ex_load} = ev ? {lo, hi, 1'b1} : {ex_lo, ex_hi, 1'b0};
      @(posedge ref_clk) #1;
      {cc_load, ex_load} = 2'h0;
      run_line(ev ? 10'h11c : 10'h015);
      i_vci_tv_model.dec_cc(v);
      i_vci_tv_model.scan(h, p);
      cmp(v, {~^hi[6:0], hi[6:0], ~^lo[6:0], lo[6:0]});
      cmp(p, 0);
    end
  endtask
  // one copy-management line, sent or suppressed
  task t_cgms(input [9:0] n, input [7:0] f, s, t, input nt, on);
    reg [19:0] v;
    integer    h, p;
    begin
      {cm1, cm2, cm3, ntsc_mode} = {f, s, t, nt};
      run_line(n);
      i_vci_tv_model.scan(h, p);
      i_vci_tv_model.dec_cg(v);
      cmp(on ? v : h, on ? cg_exp(f, s, t) : 0);
      cmp(p > 0, !on);
    end
  endtask
  // fill the fifo until it refuses, then drain it empty
  task t_fifo;
    begin
      line_number = 10'h064;
      stall = 1'b1;
      repeat (40) @(posedge ref_clk) #1;
      cmp(pix_ready, 0);
      {stall, pix_valid} = 2'h0;
      repeat (40) @(posedge ref_clk) #1;
      cmp(out_valid, 0);
      pix_valid = 1'b1;
    end
  endtask
  // verdict and end of run
  task results;
    begin
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // cut a hang short
  always @(posedge ref_clk)
  begin
    tick++;
    if (tick == 40000)
    begin
      err_count++;
      results;
    end
  end
  // main sequence
  initial
  begin
    {rst, line_start, field_even, cc_load, ex_load, stall} = 6'h20;
    {ntsc_mode, pix_valid, pix_data, line_number} = {2'h3, 8'hc3, 10'h0};
    {cc_lo, cc_hi, ex_lo, ex_hi, cm1, cm2, cm3} = 56'h0;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_caption(0, 8'h14, 8'h2c);
    t_caption(1, 8'h15, 8'h2f);
    t_caption(0, 8'h00, 8'h00);
    t_caption(0, 8'h48, 8'h49);
    t_cgms(10'h014, 8'h3a, 8'hc5, 8'h96, 1, 1);
    t_cgms(10'h11b, 8'h45, 8'h3c, 8'ha1, 1, 1);
    t_cgms(10'h11b, 8'h30, 8'h3c, 8'ha1, 1, 0);
    t_cgms(10'h014, 8'h70, 8'h3c, 8'ha1, 0, 0);
    t_cgms(10'h014, 8'h50, 8'h3c, 8'ha1, 1, 0);
    t_fifo;
    results;
  end
endmodule // test_vci_inserter

/* File: sim/vci_inserter_sva.sv */
// port assertions for the vbi inserter
`timescale 1ns/1ps
`include "vci_defs.vh"
module vci_inserter_sva (
  // clock and reset
  input wire       ref_clk,
  input wire       rst,
  // timing and config
  input wire       line_start,
  input wire [9:0] line_number,
  input wire       ntsc_mode,
  input wire [7:0] copy_mgmt_reg_first,
  // output stream and status
  input wire       out_valid,
  input wire       out_ready,
  input wire [7:0] out_data,
  input wire       insert_active
);
  reg [10:0] act_cnt_reg;
  wire cg_line = line_number == `VCI_CGMS_LINE_ODD ||
                 line_number == `VCI_CGMS_LINE_EVEN;
  wire cc_line = line_number == `VCI_CC_LINE_ODD ||
                 line_number == `VCI_CC_LINE_EVEN;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // length of the current insertion
  always @(posedge ref_clk or posedge rst)
    if (rst)
      act_cnt_reg <= 11'h000;
    else
      act_cnt_reg <= insert_active ? act_cnt_reg + 11'h001 : 11'h000;
  chk_out_hold:
    assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_data)) else $error("stalled sample lost");
  chk_cc_odd:
    assert property (line_start && line_number == `VCI_CC_LINE_ODD
      |-> ##[1:400] insert_active) else $error("no odd caption");
  chk_cc_even:
    assert property (line_start && line_number == `VCI_CC_LINE_EVEN
      |-> ##[1:400] insert_active) else $error("no even caption");
  chk_vbi_only:
    assert property ($rose(insert_active) |-> cc_line || cg_line)
      else $error("insert on a plain line");
  chk_cgms_ntsc:
    assert property ($rose(insert_active) && cg_line |-> ntsc_mode)
      else $error("copy data outside ntsc");
  chk_cgms_odd:
    assert property ($rose(insert_active) && line_number ==
      `VCI_CGMS_LINE_ODD |-> copy_mgmt_reg_first[5]) else $error("odd off");
  chk_cgms_even:
    assert property ($rose(insert_active) && line_number ==
      `VCI_CGMS_LINE_EVEN |-> copy_mgmt_reg_first[6]) else $error("even off");
  chk_act_bound:
    assert property (act_cnt_reg < 11'h708)
      else $error("insertion runs too long");
endmodule // vci_inserter_sva
bind vci_inserter vci_inserter_sva i_vci_inserter_sva (
  .ref_clk(ref_clk), .rst(rst), .line_start(line_start),
  .line_number(line_number), .ntsc_mode(ntsc_mode),
  .copy_mgmt_reg_first(copy_mgmt_reg_first), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data),
  .insert_active(insert_active));

/* File: sim/vci_tv_model.sv */
// receiver model: drains the sample stream and decodes vbi lines
`timescale 1ns/1ps
module vci_tv_model (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // sample stream
  input  wire       out_valid,
  output reg        out_ready,
  input  wire [7:0] out_data,
  // long stall request
  input  wire       stall
);
  logic [7:0] got[$];
  reg   [2:0] cyc_reg;
  // take samples, ready low one cycle in eight
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {out_ready, cyc_reg} <= 4'h0;
    else
    begin
      if (out_valid && out_ready)
        got.push_back(out_data);
      cyc_reg   <= cyc_reg + 3'h1;
      out_ready <= !stall && (cyc_reg != 3'h7);
    end
  end
  // caption: start bit follows two blank bits and a low half; the
  // lead-in blank before the first run-in pulse is far longer
  task dec_cc(output [15:0] v);
    integer i, n, s;
    begin
      s = 0;
      n = 0;
      for (i = 16; i < got.size() && s == 0; i++)
        if (got[i] == 8'h7e && n >= 70 && n < 150)
          s = i;
        else
          n = (got[i] == 8'h10) ? n + 1 : 0;
      for (i = 0; i < 16; i++)
        v[i] = (got[s + 39 * i + 58] == 8'h7e);
    end
  endtask
  // copy-management: first high sample is the reference pulse
  task dec_cg(output [19:0] v);
    integer i, r;
    begin
      r = 0;
      for (i = got.size() - 1; i >= 16; i--)
        if (got[i] == 8'h7e)
          r = i;
      for (i = 0; i < 20; i++)
        v[i] = (got[r + 44 * i + 66] == 8'h7e);
    end
  endtask
  // count high and pixel samples past the fifo lag
  task scan(output integer hi, output integer px);
    integer i;
    begin
      {hi, px} = 0;
      for (i = 16; i < got.size(); i++)
      begin
        hi += (got[i] == 8'h7e);
        px += (got[i] == 8'hc3);
      end
    end
  endtask
endmodule // vci_tv_model
